// File: include/cmpctl_pkg.sv
/*
  constants for the comparator control block: register indexes, field positions,
  reset values, input select codes.
  assumes a plain one-cycle register port, one 10 mhz clock.
*/
`default_nettype none
package cmpctl_pkg;
  // ******************************
  // register indexes
  // ******************************
  localparam logic [3:0] ADDR_CTRL0  = 4'h0;
  localparam logic [3:0] ADDR_CTRL1  = 4'h1;
  localparam logic [3:0] ADDR_MIRROR = 4'h2;
  localparam logic [3:0] ADDR_STATUS = 4'h3;
  localparam logic [3:0] ADDR_MASK   = 4'h4;
  // ******************************
  // control 0 fields
  // ******************************
  localparam int C0_ENABLE = 7;
  localparam int C0_RESULT = 6;
  localparam int C0_PINOE  = 5;
  localparam int C0_INVERT = 4;
  localparam int C0_SPEED  = 2;
  localparam int C0_HYST   = 1;
  localparam int C0_SYNC   = 0;
  localparam logic [7:0] C0_WMASK = 8'hb7;
  // ******************************
  // control 1 fields
  // ******************************
  localparam int C1_RISE   = 7;
  localparam int C1_FALL   = 6;
  localparam int C1_PSEL   = 4;
  localparam int C1_NSEL   = 0;
  localparam logic [7:0] C1_WMASK = 8'hf1;
  // ******************************
  // status fields and reset values
  // ******************************
  localparam int ST_EVENT = 0;
  localparam logic [7:0] RESET_CTRL = 8'h00;
  localparam logic [0:0] RESET_BIT  = 1'h0;
  // ******************************
  // positive input codes
  // ******************************
  localparam logic [1:0] PSEL_PIN = 2'h0;
  localparam logic [1:0] PSEL_DAC = 2'h1;
  localparam logic [1:0] PSEL_FIXED = 2'h2;
endpackage
`default_nettype wire

// File: hw/cmpctl_top.sv
/*
  control and event logic around one analog comparator: power and hysteresis
  selects, input routing, polarity, pin enable, edge flag and interrupt.
  assumes the raw comparison arrives asynchronously from the analog core.
*/
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module cmpctl_top (
  input  wire logic       ref_clk_in,
  input  wire logic       arst_n_in,
  input  wire logic [3:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  input  wire logic       raw_cmp_in,
  output logic      [7:0] rdata_out,
  output logic            cmp_enable_out,
  output logic            speed_power_select_out,
  output logic            hysteresis_enable_out,
  output logic            output_sync_select_out,
  output logic      [1:0] positive_input_select_out,
  output logic            negative_input_select_out,
  output logic            comparator_result_out,
  output logic            pin_drive_out,
  output logic            pin_oe_out,
  output logic            irq_out
);
  // ******************************
  // reset release
  // ******************************
  logic rst_s1_r;
  logic rst_n_r;
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  // ******************************
  // raw comparison synchroniser
  // ******************************
  logic raw_s1_r;
  logic raw_s2_r;
  always_ff @(posedge ref_clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      raw_s1_r <= 1'b0;
      raw_s2_r <= 1'b0;
    end else begin
      raw_s1_r <= raw_cmp_in;
      raw_s2_r <= raw_s1_r;
    end
  end

  // ******************************
  // register decode
  // ******************************
  logic [7:0] ctrl0_r;
  logic [7:0] ctrl1_r;
  logic [7:0] mask_r;
  logic       event_r;
  logic       result_r;
  wire        wr_c0   = wr_in && (addr_in == cmpctl_pkg::ADDR_CTRL0);
  wire        wr_c1   = wr_in && (addr_in == cmpctl_pkg::ADDR_CTRL1);
  wire        wr_mask = wr_in && (addr_in == cmpctl_pkg::ADDR_MASK);
  wire        rd_stat = rd_in && (addr_in == cmpctl_pkg::ADDR_STATUS);
  wire [7:0]  c0_view = (ctrl0_r & cmpctl_pkg::C0_WMASK)
                        | ({7'h00, result_r} << cmpctl_pkg::C0_RESULT);
  wire [7:0]  rd_mux  = (addr_in == cmpctl_pkg::ADDR_CTRL0)  ? c0_view :
                        (addr_in == cmpctl_pkg::ADDR_CTRL1)  ? ctrl1_r :
                        (addr_in == cmpctl_pkg::ADDR_MIRROR) ? {7'h00, result_r} :
                        (addr_in == cmpctl_pkg::ADDR_STATUS) ? {7'h00, event_r} :
                        (addr_in == cmpctl_pkg::ADDR_MASK)   ? mask_r : 8'h00;

  always_ff @(posedge ref_clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ctrl0_r <= cmpctl_pkg::RESET_CTRL;
      ctrl1_r <= cmpctl_pkg::RESET_CTRL;
      mask_r  <= cmpctl_pkg::RESET_CTRL;
    end else begin
      if (wr_c0) begin
        ctrl0_r <= wdata_in & cmpctl_pkg::C0_WMASK;
      end
      if (wr_c1) begin
        ctrl1_r <= wdata_in & cmpctl_pkg::C1_WMASK;
      end
      if (wr_mask) begin
        mask_r <= {7'h00, wdata_in[cmpctl_pkg::ST_EVENT]};
      end
    end
  end

  // ******************************
  // result polarity and edges
  // ******************************
  // invert applied after sync so a polarity write also counts as an edge
  wire res_nxt  = raw_s2_r ^ ctrl0_r[cmpctl_pkg::C0_INVERT];
  wire fall     = result_r && !res_nxt;
  wire rise     = !result_r && res_nxt;
  wire hit      = (fall && ctrl1_r[cmpctl_pkg::C1_FALL])
                  || (rise && ctrl1_r[cmpctl_pkg::C1_RISE]);
  wire ev_nxt   = hit ? 1'b1 : (rd_stat ? 1'b0 : event_r);  // set beats read-clear
  wire irq_nxt  = ev_nxt && mask_r[cmpctl_pkg::ST_EVENT];
  wire pin_en   = ctrl0_r[cmpctl_pkg::C0_PINOE];

  always_ff @(posedge ref_clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      result_r <= cmpctl_pkg::RESET_BIT;
      event_r  <= cmpctl_pkg::RESET_BIT;
    end else begin
      result_r <= res_nxt;
      event_r  <= ev_nxt;
    end
  end

  // ******************************
  // registered outputs
  // ******************************
  always_ff @(posedge ref_clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rdata_out                 <= 8'h00;
      cmp_enable_out            <= 1'b0;
      speed_power_select_out    <= 1'b0;
      hysteresis_enable_out     <= 1'b0;
      output_sync_select_out    <= 1'b0;
      positive_input_select_out <= cmpctl_pkg::PSEL_PIN;
      negative_input_select_out <= 1'b0;
      comparator_result_out     <= 1'b0;
      pin_drive_out             <= 1'b0;
      pin_oe_out                <= 1'b0;
      irq_out                   <= 1'b0;
    end else begin
      rdata_out                 <= rd_in ? rd_mux : 8'h00;
      cmp_enable_out            <= ctrl0_r[cmpctl_pkg::C0_ENABLE];
      speed_power_select_out    <= ctrl0_r[cmpctl_pkg::C0_SPEED];
      hysteresis_enable_out     <= ctrl0_r[cmpctl_pkg::C0_HYST];
      output_sync_select_out    <= ctrl0_r[cmpctl_pkg::C0_SYNC];
      positive_input_select_out <= ctrl1_r[cmpctl_pkg::C1_PSEL +: 2];
      negative_input_select_out <= ctrl1_r[cmpctl_pkg::C1_NSEL];
      comparator_result_out     <= res_nxt;
      // pad direction follows the pin enable bit, which also gates the drive
      pin_drive_out             <= pin_en && res_nxt;
      pin_oe_out                <= pin_en;
      irq_out                   <= irq_nxt;
    end
  end

  // ******************************
  // checks
  // ******************************
  property p_speed;
    @(posedge ref_clk_in) disable iff (!rst_n_r)
      wr_c0 |=> ##1 (speed_power_select_out == $past(wdata_in[cmpctl_pkg::C0_SPEED], 2));
  endproperty
  a_speed: assert property (p_speed) else $error("speed select wrong");

  property p_hyst;
    @(posedge ref_clk_in) disable iff (!rst_n_r)
      wr_c0 |=> ##1 (hysteresis_enable_out == $past(wdata_in[cmpctl_pkg::C0_HYST], 2));
  endproperty
  a_hyst: assert property (p_hyst) else $error("hysteresis enable wrong");

  property p_fall;
    @(posedge ref_clk_in) disable iff (!rst_n_r)
      (fall && ctrl1_r[cmpctl_pkg::C1_FALL]) |=> event_r;
  endproperty
  a_fall: assert property (p_fall) else $error("falling edge lost");

  property p_psel;
    @(posedge ref_clk_in) disable iff (!rst_n_r)
      wr_c1 |=> ##1 (positive_input_select_out == $past(wdata_in[5:4], 2));
  endproperty
  a_psel: assert property (p_psel) else $error("input select wrong");

  property p_invert;
    @(posedge ref_clk_in) disable iff (!rst_n_r)
      1'b1 |=> (result_r == ($past(raw_s2_r) ^ $past(ctrl0_r[cmpctl_pkg::C0_INVERT])));
  endproperty
  a_invert: assert property (p_invert) else $error("polarity wrong");

  property p_pin;
    @(posedge ref_clk_in) disable iff (!rst_n_r)
      !pin_oe_out |-> !pin_drive_out;
  endproperty
  a_pin: assert property (p_pin) else $error("pin driven while internal");

  property p_mirror;
    @(posedge ref_clk_in) disable iff (!rst_n_r)
      (rd_in && addr_in == cmpctl_pkg::ADDR_MIRROR) |=> (rdata_out == {7'h00, $past(result_r)});
  endproperty
  a_mirror: assert property (p_mirror) else $error("mirror wrong");

  property p_rise;
    @(posedge ref_clk_in) disable iff (!rst_n_r)
      (rise && ctrl1_r[cmpctl_pkg::C1_RISE])
        |=> (event_r && (irq_out == $past(mask_r[cmpctl_pkg::ST_EVENT])));
  endproperty
  a_rise: assert property (p_rise) else $error("rising edge lost");

  property p_quiet;
    @(posedge ref_clk_in) disable iff (!rst_n_r)
      (!hit && !event_r) |=> !event_r;
  endproperty
  a_quiet: assert property (p_quiet) else $error("flag set without edge");

  // a status read without a coincident edge must clear the flag
  property p_clear;
    @(posedge ref_clk_in) disable iff (!rst_n_r)
      (rd_stat && !hit) |=> !event_r;
  endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared by read");
endmodule
`default_nettype wire

// File: testbench/cmpctl_core_model.sv
/*
  analog core model: picks one of three input levels by the select code.
  assumes levels are plain bits set by the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module cmpctl_core_model (
  input  wire logic       en_in,
  input  wire logic [1:0] psel_in,
  input  wire logic [2:0] lvl_in,
  output logic            raw_out
);
  // disabled core reads low; code 11 is unused and reads low
  assign raw_out = en_in & (psel_in != 2'h3) & lvl_in[psel_in];
endmodule
`default_nettype wire

// File: testbench/cmpctl_top_tb.sv
/*
  bench for the comparator control block: registers, routing, polarity,
  pin enable, edge flag and interrupt.
  assumes the package and the core model file.
*/
`timescale 1ns/1ps
`default_nettype none
module cmpctl_top_tb;
  logic        clk = 0, rst_n = 0, wr = 0, rd = 0, rd_seen = 0;
  logic        raw, en, spd, hys, res, drv, oe, irq, r, e, sync, nsel;
  logic [3:0]  addr = 4'h0;
  logic [7:0]  wdata = 8'h00, rdata, v;
  logic [2:0]  lvl = 3'h0;
  logic [1:0]  psel;
  logic [16:0] lf = 17'h11597;
  logic [7:0]  exp_q[$];
  int          fails = 0, check_count = 0;
  always #50 clk = ~clk;
  cmpctl_top uut (.ref_clk_in(clk), .arst_n_in(rst_n), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .raw_cmp_in(raw),
    .rdata_out(rdata), .cmp_enable_out(en), .speed_power_select_out(spd),
    .hysteresis_enable_out(hys), .output_sync_select_out(sync),
    .positive_input_select_out(psel), .negative_input_select_out(nsel),
    .comparator_result_out(res), .pin_drive_out(drv), .pin_oe_out(oe),
    .irq_out(irq));
  cmpctl_core_model core (.en_in(en), .psel_in(psel), .lvl_in(lvl), .raw_out(raw));
  // ******************************
  // bus tasks and checking
  // ******************************
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] ex);
    check_count++;
    if (got !== ex) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] ex);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    exp_q.push_back(ex);
    @(posedge clk);
    rd   <= 1'b0;
  endtask
  // two sync flops plus output register need a few edges
  task automatic settle;
    repeat (6) @(negedge clk);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk) rd_seen <= rd;
  always @(negedge clk) begin
    if (rd_seen) chk("rdata", rdata, exp_q.pop_front());
  end
  initial begin
    repeat (4000) @(posedge clk);
    fails++;
    give_verdict;
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd_reg(cmpctl_pkg::ADDR_CTRL0, cmpctl_pkg::RESET_CTRL);
    rd_reg(cmpctl_pkg::ADDR_STATUS, 8'h00);
    wr_reg(4'h5, 8'hff);
    rd_reg(4'h5, 8'h00);
    wr_reg(cmpctl_pkg::ADDR_CTRL1, 8'hfe);
    rd_reg(cmpctl_pkg::ADDR_CTRL1, 8'hfe & cmpctl_pkg::C1_WMASK);
    wr_reg(cmpctl_pkg::ADDR_CTRL1, 8'h00);
    $display("registers done");
    for (int i = 0; i < 6; i++) begin
      lf = {lf[15:0], lf[16] ^ lf[13]};
      v = lf[7:0];
      lvl <= {2'h0, lf[8]};
      wr_reg(cmpctl_pkg::ADDR_CTRL0, v);
      settle;
      r = (v[7] & lf[8]) ^ v[4];
      chk("outs", {1'b0, en, sync, oe, drv, res, hys, spd},
          {1'b0, v[7], v[0], v[5], r & v[5], r, v[1], v[2]});
      rd_reg(cmpctl_pkg::ADDR_CTRL0, (v & cmpctl_pkg::C0_WMASK) | {1'b0, r, 6'h0});
      rd_reg(cmpctl_pkg::ADDR_MIRROR, {7'h0, r});
    end
    $display("control done");
    wr_reg(cmpctl_pkg::ADDR_CTRL0, 8'h80);
    for (int p = 0; p < 3; p++) begin
      lvl <= 3'h1 << p;
      wr_reg(cmpctl_pkg::ADDR_CTRL1, {2'h0, p[1:0], 3'h0, p[0]});
      settle;
      chk("route", {4'h0, nsel, psel, res}, {4'h0, p[0], p[1:0], 1'b1});
    end
    wr_reg(cmpctl_pkg::ADDR_CTRL1, 8'h00);
    lvl <= 3'h0;
    settle;
    for (int i = 0; i < 4; i++) begin
      wr_reg(cmpctl_pkg::ADDR_MASK, {7'h0, ~i[1]});
      wr_reg(cmpctl_pkg::ADDR_CTRL1, i[1] ? 8'h40 : 8'h80);
      settle;
      lvl <= {2'h0, ~i[0]};
      settle;
      e = ~(i[1] ^ i[0]);
      chk("irq", {7'h0, irq}, {7'h0, e & ~i[1]});
      rd_reg(cmpctl_pkg::ADDR_STATUS, {7'h0, e});
      rd_reg(cmpctl_pkg::ADDR_STATUS, 8'h00);
    end
    $display("events done");
    settle;
    give_verdict;
  end
endmodule
`default_nettype wire
